// File: dsp_byte_port_cfg.svh
// Constants for the byte port sample packer: counts, widths and timing
`ifndef DSP_BYTE_PORT_CFG_SVH
`define DSP_BYTE_PORT_CFG_SVH

// ==========================================================
// Data path shape
`define DBP_BYTE_W 8
`define DBP_SAMPLE_W 16
`define DBP_BYTES_PER_WORD 4
`define DBP_FIFO_DEPTH 4096

// ==========================================================
// Clock and timing
`define DBP_CLK_PERIOD_NS 20
`define DBP_TOKEN_FORCE_NS 1000
`define DBP_TOKEN_FORCE_CYC ((`DBP_TOKEN_FORCE_NS + `DBP_CLK_PERIOD_NS - 1) / `DBP_CLK_PERIOD_NS)

// ==========================================================
// Synchroniser depth, byte index reset value and last byte index
`define DBP_SYNC_STAGES 3
`define DBP_BYTE_IDX_RST 2'h0
`define DBP_LAST_BYTE 2'h3

`endif

// File: dsp_byte_port_pkg.sv
// Types shared by the byte port sample packer
`default_nettype none

package dsp_byte_port_pkg;

  // ==========================================================
  // Controller states
  typedef enum logic [2:0]
  {
    st_idle,
    st_read_first,
    st_take_first,
    st_read_second,
    st_take_second,
    st_setup,
    st_strobe,
    st_release
  } packer_state_t;

endpackage : dsp_byte_port_pkg

`default_nettype wire

// File: dsp_byte_port_sample_packer.sv
// Packs pairs of FIFO samples into longwords and sends them over a byte-wide strobe/ready link
`include "dsp_byte_port_cfg.svh"
`default_nettype none

// Contract
// (R1) Eight-bit data path to receiver, one byte per handshake.
// (R2) Take 16-bit samples from the carrier FIFO and turn them into bytes.
// (R3) Two samples form one 32-bit longword, sent as four bytes.
// (R4) Least significant byte of each longword goes first.
// (R5) Once a longword's first byte starts, all four bytes are sent.
// (R6) Each byte moves by low strobe with data, answered by low ready.
// (R7) Strobe stays inactive until the FIFO reports half full.
// (R8) At half full send one longword, then hold strobe until half full again.
// (R9) While half full persists, keep sending longwords back to back.
// (R10) Aim at about 14 megabytes per second inside a burst; the code takes over 10 cycles of 20 ns per byte, under 4 MB/s.
// (R11) Always the output end; direction change requests are ignored.
// (R12) At power up drive token lines so the receiver becomes input.
// (R13) Receiver works only as input; link is one way.
// (R14) No transfers start while the FIFO reports empty.
// (R15) Low controller clear holds the controller cleared; high resumes.
// (R16) Byte order: first sample low, high, second sample low, high.
// (R17) Reset or clear returns to idle, strobe off, no partial word.
module dsp_byte_port_sample_packer #(
  parameter int SAMPLE_W = `DBP_SAMPLE_W,
  parameter int FIFO_DEPTH = `DBP_FIFO_DEPTH,
  parameter int TOKEN_FORCE_CYC = `DBP_TOKEN_FORCE_CYC
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,

  // Carrier sample FIFO port
  input wire logic [SAMPLE_W-1:0] fifo_data,
  input wire logic fifo_half_full,
  input wire logic fifo_empty,
  output logic fifo_read,

  // Host control bit
  input wire logic controller_clear_n,

  // Link data bus
  output logic [`DBP_BYTE_W-1:0] byte_data_out,
  output logic byte_data_oe,

  // Link handshake
  output logic byte_strobe_n,
  input wire logic byte_ready_n,

  // Link token lines, open drain
  input wire logic token_request_n_in,
  output logic token_request_n_out,
  output logic token_request_n_oe,
  input wire logic token_ack_n_in,
  output logic token_ack_n_out,
  output logic token_ack_n_oe,

  // Status
  output logic link_busy
);

  // ==========================================================
  // Local sizes
  localparam int WORD_W = 2 * SAMPLE_W;
  localparam int FORCE_W = $clog2(TOKEN_FORCE_CYC + 1);
  localparam logic [FORCE_W-1:0] FORCE_LOAD = FORCE_W'(TOKEN_FORCE_CYC);

  // ==========================================================
  // Synchronised pins
  logic half_full_level;
  logic empty_level;
  logic ready_n_level;
  logic clear_n_level;

  // Pins from the carrier and the receiver cross into core_clk
  // Reset levels: clear_n high, ready_n high, empty high, half_full low
  pin_sync #(
    .WIDTH(4),
    .RESET_VALUE(4'he)
  ) u_pin_sync (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .pin({controller_clear_n, byte_ready_n, fifo_empty, fifo_half_full}),
    .level({clear_n_level, ready_n_level, empty_level, half_full_level})
  );

  // Token lines are read by nobody: direction requests have no effect
  logic token_lines_unused;
  assign token_lines_unused = token_request_n_in ^ token_ack_n_in; // see (R11)

  // ==========================================================
  // Token forcer state
  logic [FORCE_W-1:0] force_cnt;
  logic [FORCE_W-1:0] next_force_cnt;
  logic forcing;

  assign forcing = (force_cnt != '0);

  // Count down the power-up forcing window once
  always_comb
  begin
    next_force_cnt = force_cnt;
    if (forcing)
    begin
      next_force_cnt = force_cnt - FORCE_W'(1);
    end
  end

  // Forcing window register
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      force_cnt <= FORCE_LOAD;
    end
    else
    begin
      force_cnt <= next_force_cnt;
    end
  end

  // ==========================================================
  // Controller state
  dsp_byte_port_pkg::packer_state_t state;
  dsp_byte_port_pkg::packer_state_t next_state;
  logic [WORD_W-1:0] word;
  logic [WORD_W-1:0] next_word;
  logic [1:0] byte_idx;
  logic [1:0] next_byte_idx;
  logic [`DBP_BYTE_W-1:0] data_reg;
  logic [`DBP_BYTE_W-1:0] next_data_reg;
  logic strobe_n_reg;
  logic next_strobe_n_reg;
  logic start_ok;

  // A longword may start only when half full and not empty
  // Forcing must end first, or the receiver may not yet be an input
  assign start_ok = half_full_level && !empty_level && !forcing; // see (R7) see (R14)

  // Next-state and datapath decisions
  always_comb
  begin
    next_state = state;
    next_word = word;
    next_byte_idx = byte_idx;
    next_data_reg = data_reg;
    next_strobe_n_reg = strobe_n_reg;
    if (!clear_n_level)
    begin
      // Cleared controller holds idle with nothing pending
      next_state = dsp_byte_port_pkg::st_idle; // see (R15) see (R17)
      next_byte_idx = `DBP_BYTE_IDX_RST;
      next_strobe_n_reg = 1'b1;
    end
    else
    begin
      case (state)
        dsp_byte_port_pkg::st_idle:
        begin
          next_strobe_n_reg = 1'b1;
          next_byte_idx = `DBP_BYTE_IDX_RST;
          if (start_ok)
          begin
            next_state = dsp_byte_port_pkg::st_read_first; // see (R8)
          end
        end
        dsp_byte_port_pkg::st_read_first:
        begin
          next_state = dsp_byte_port_pkg::st_take_first;
        end
        dsp_byte_port_pkg::st_take_first:
        begin
          // First sample fills the low half
          next_word[SAMPLE_W-1:0] = fifo_data; // see (R2) see (R16)
          next_state = dsp_byte_port_pkg::st_read_second;
        end
        dsp_byte_port_pkg::st_read_second:
        begin
          next_state = dsp_byte_port_pkg::st_take_second;
        end
        dsp_byte_port_pkg::st_take_second:
        begin
          // Second sample fills the high half
          next_word[WORD_W-1:SAMPLE_W] = fifo_data; // see (R3) see (R16)
          next_state = dsp_byte_port_pkg::st_setup;
        end
        dsp_byte_port_pkg::st_setup:
        begin
          // Put the byte on the bus a cycle before the strobe
          next_data_reg = word[byte_idx*`DBP_BYTE_W +: `DBP_BYTE_W]; // see (R1) see (R4)
          if (ready_n_level)
          begin
            next_state = dsp_byte_port_pkg::st_strobe;
          end
        end
        dsp_byte_port_pkg::st_strobe:
        begin
          // Strobe held low until the receiver answers with ready
          next_strobe_n_reg = 1'b0; // see (R6)
          if (!strobe_n_reg && !ready_n_level)
          begin
            next_strobe_n_reg = 1'b1;
            next_state = dsp_byte_port_pkg::st_release;
          end
        end
        dsp_byte_port_pkg::st_release:
        begin
          // Wait for ready to go away before the next byte
          if (ready_n_level)
          begin
            if (byte_idx != `DBP_LAST_BYTE)
            begin
              // Word already captured, so the rest follows unless the controller is cleared
              next_byte_idx = byte_idx + 2'h1; // see (R5)
              next_state = dsp_byte_port_pkg::st_setup;
            end
            else if (start_ok)
            begin
              // Half full still present: go straight on
              next_byte_idx = `DBP_BYTE_IDX_RST;
              next_state = dsp_byte_port_pkg::st_read_first; // see (R9) see (R10)
            end
            else
            begin
              next_state = dsp_byte_port_pkg::st_idle; // see (R8)
            end
          end
        end
        default:
        begin
          next_state = dsp_byte_port_pkg::st_idle;
        end
      endcase
    end
  end

  // Controller registers
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state <= dsp_byte_port_pkg::st_idle; // see (R17)
      word <= '0;
      byte_idx <= `DBP_BYTE_IDX_RST;
      data_reg <= 8'h00;
      strobe_n_reg <= 1'b1;
    end
    else
    begin
      state <= next_state;
      word <= next_word;
      byte_idx <= next_byte_idx;
      data_reg <= next_data_reg;
      strobe_n_reg <= next_strobe_n_reg;
    end
  end

  // ==========================================================
  // Outputs
  // FIFO read pulse one cycle before each capture
  logic read_state;

  // Read states decoded from the state register
  always_comb
  begin
    read_state = 1'b0;
    case (state)
      dsp_byte_port_pkg::st_read_first:
      begin
        read_state = 1'b1;
      end
      dsp_byte_port_pkg::st_read_second:
      begin
        read_state = 1'b1;
      end
      default:
      begin
        read_state = 1'b0;
      end
    endcase
  end

  // Reads stop at once while the controller is cleared
  assign fifo_read = clear_n_level && read_state; // see (R2) see (R15)

  // Link data from its register, bus always driven
  assign byte_data_out = data_reg; // see (R1)
  assign byte_data_oe = 1'b1; // see (R11) see (R13)

  // Strobe straight from its register, so it never glitches
  assign byte_strobe_n = strobe_n_reg; // see (R6)

  // Acknowledge token line pulled low during the forcing window, released after
  assign token_ack_n_out = 1'b0;
  assign token_ack_n_oe = forcing; // see (R12)

  // Request line never driven: the receiver cannot take the link
  assign token_request_n_out = 1'b0;
  assign token_request_n_oe = 1'b0; // see (R11)

  // Busy while a longword is in flight
  assign link_busy = (state != dsp_byte_port_pkg::st_idle);

endmodule : dsp_byte_port_sample_packer

`default_nettype wire

// File: dsp_byte_port_sample_packer_tb_top.sv
// Self-checking bench for the byte port sample packer
`default_nettype none
module dsp_byte_port_sample_packer_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 1'b0, sys_rst = 1'b1, half = 1'b0, empty = 1'b1, clr_n = 1'b1, req_pull = 1'b0;
  logic [3:0] stall = 4'h0;
  logic [15:0] fdata = 16'h0000, smp = 16'h1a2b;
  logic rd, oe, stb_n, rdy_n, busy, rq_out, rq_oe, ack_out, ack_oe;
  logic [7:0] bdata;
  logic [7:0] exp_q[$];
  int miscompares = 0, num_checks = 0;
  wire rq_in = req_pull ? 1'b0 : (rq_oe ? rq_out : 1'b1);
  wire ack_in = ack_oe ? ack_out : 1'b1;
  // Clock
  always #10 core_clk = ~core_clk;
  // Packer with a short token window
  dsp_byte_port_sample_packer #(.TOKEN_FORCE_CYC(2)) dut (.core_clk(core_clk), .sys_rst(sys_rst), .fifo_data(fdata),
    .fifo_half_full(half), .fifo_empty(empty), .fifo_read(rd), .controller_clear_n(clr_n), .byte_data_out(bdata),
    .byte_data_oe(oe), .byte_strobe_n(stb_n), .byte_ready_n(rdy_n), .token_request_n_in(rq_in),
    .token_request_n_out(rq_out), .token_request_n_oe(rq_oe), .token_ack_n_in(ack_in), .token_ack_n_out(ack_out),
    .token_ack_n_oe(ack_oe), .link_busy(busy));
  // Receiver
  dsp_rx_model rx (.core_clk(core_clk), .sys_rst(sys_rst), .byte_data(bdata), .byte_strobe_n(stb_n),
    .byte_ready_n(rdy_n), .stall_cyc(stall));
  // Fifo: sample appears the cycle after a read
  always @(posedge core_clk)
    if (rd)
    begin
      fdata <= smp;
      smp <= smp + 16'h1357;
      exp_q.push_back(smp[7:0]);
      exp_q.push_back(smp[15:8]);
    end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask : cyc
  task automatic cmp_words();
    chk(rx.got.size(), exp_q.size());
    foreach (exp_q[i]) chk(rx.got[i], exp_q[i]);
    rx.got.delete();
    exp_q.delete();
  endtask : cmp_words
  task automatic wait_idle();
    for (int i = 0; i < 3000 && busy !== 1'b0; i++) cyc(1);
    chk(busy, 0);
  endtask : wait_idle
  // Reset values and token forcing
  task automatic t_reset();
    cyc(3);
    chk({stb_n, busy, ack_oe, ack_out, rq_oe, oe}, 6'h29);
    @(posedge core_clk) sys_rst <= 1'b0;
    cyc(2);
    chk(ack_oe, 1);
    cyc(4);
    chk({stb_n, busy, ack_oe}, 3'h4);
  endtask : t_reset
  // No sending while empty or below half full
  task automatic t_gate();
    @(posedge core_clk) half <= 1'b1;
    cyc(20);
    chk(exp_q.size(), 0);
    @(posedge core_clk)
    begin
      half <= 1'b0;
      empty <= 1'b0;
    end
    cyc(20);
    chk({exp_q.size() == 0, stb_n}, 2'h3);
  endtask : t_gate
  // One longword per half-full event
  task automatic one_word();
    @(posedge core_clk) half <= 1'b1;
    for (int i = 0; i < 500 && rd !== 1'b1; i++) cyc(1);
    chk(rd, 1);
    @(posedge core_clk) half <= 1'b0;
    wait_idle();
    chk(rx.got.size(), 4);
    cmp_words();
  endtask : one_word
  // Back-to-back words, slow receiver, token request ignored
  task automatic t_burst();
    int gaps = 0;
    @(posedge core_clk)
    begin
      stall <= 4'h3;
      req_pull <= 1'b1;
      half <= 1'b1;
    end
    for (int i = 0; i < 3000 && rx.got.size() < 12; i++)
    begin
      cyc(1);
      gaps += (rx.got.size() > 0 && busy !== 1'b1);
    end
    chk(rx.got.size() >= 12, 1);
    chk({rq_oe, rq_out, oe}, 3'h1);
    @(posedge core_clk) half <= 1'b0;
    wait_idle();
    chk(gaps, 0);
    cmp_words();
  endtask : t_burst
  // Clear in mid-word, then a clean restart
  task automatic t_clear();
    @(posedge core_clk)
    begin
      req_pull <= 1'b0;
      stall <= 4'hf;
      half <= 1'b1;
    end
    for (int i = 0; i < 500 && stb_n !== 1'b0; i++) cyc(1);
    chk(stb_n, 0);
    @(posedge core_clk)
    begin
      clr_n <= 1'b0;
      half <= 1'b0;
    end
    cyc(10);
    chk({busy, stb_n}, 2'h1);
    @(posedge core_clk)
    begin
      clr_n <= 1'b1;
      stall <= 4'h0;
    end
    cyc(10);
    chk(busy, 0);
    rx.got.delete();
    exp_q.delete();
    one_word();
  endtask : t_clear
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : finish_test
  // Main sequence
  initial
  begin
    t_reset();
    t_gate();
    one_word();
    t_burst();
    t_clear();
    finish_test();
  end
  // Watchdog
  initial
  begin
    #1000000;
    miscompares++;
    finish_test();
  end
endmodule : dsp_byte_port_sample_packer_tb_top
`default_nettype wire

// File: dsp_byte_port_sva.sv
// Assertions for the byte port sample packer
`default_nettype none
module dsp_byte_port_sva (
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Fifo and control
  input wire logic fifo_half_full,
  input wire logic fifo_empty,
  input wire logic fifo_read,
  input wire logic controller_clear_n,
  // Link
  input wire logic [7:0] byte_data_out,
  input wire logic byte_data_oe,
  input wire logic byte_strobe_n,
  input wire logic byte_ready_n,
  input wire logic token_request_n_oe,
  input wire logic token_ack_n_out,
  input wire logic token_ack_n_oe,
  input wire logic link_busy
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  // ==========
  // Link checks
  property p_drive; byte_data_oe && !token_request_n_oe; endproperty
  a_drive: assert property (p_drive) else $error("link not one way");
  property p_force; token_ack_n_oe |-> !token_ack_n_out && byte_strobe_n && !link_busy; endproperty
  a_force: assert property (p_force) else $error("sent while forcing");
  property p_hold; $rose(byte_strobe_n) |-> !$past(byte_ready_n) || !controller_clear_n; endproperty
  a_hold: assert property (p_hold) else $error("strobe ended early");
  property p_stable; !byte_strobe_n |=> byte_strobe_n || $stable(byte_data_out); endproperty
  a_stable: assert property (p_stable) else $error("data moved");
  // ==========
  // Fifo checks
  property p_reads; $rose(link_busy) |-> fifo_read ##1 !fifo_read ##1 fifo_read; endproperty
  a_reads: assert property (p_reads) else $error("bad read pair");
  property p_half; (!fifo_half_full) [*5] ##0 !link_busy |=> !fifo_read; endproperty
  a_half: assert property (p_half) else $error("read below half");
  property p_empty; fifo_empty [*5] ##0 !link_busy |=> !fifo_read; endproperty
  a_empty: assert property (p_empty) else $error("read while empty");
  property p_clear; (!controller_clear_n) [*8] |-> !link_busy && byte_strobe_n && !fifo_read; endproperty
  a_clear: assert property (p_clear) else $error("not cleared");
  c_word: cover property ($rose(link_busy));
  c_byte: cover property (!byte_strobe_n && !byte_ready_n);
  c_clear: cover property (!controller_clear_n && link_busy);
endmodule : dsp_byte_port_sva
bind dsp_byte_port_sample_packer dsp_byte_port_sva u_sva (.core_clk(core_clk), .sys_rst(sys_rst),
  .fifo_half_full(fifo_half_full), .fifo_empty(fifo_empty), .fifo_read(fifo_read),
  .controller_clear_n(controller_clear_n), .byte_data_out(byte_data_out), .byte_data_oe(byte_data_oe),
  .byte_strobe_n(byte_strobe_n), .byte_ready_n(byte_ready_n), .token_request_n_oe(token_request_n_oe),
  .token_ack_n_out(token_ack_n_out), .token_ack_n_oe(token_ack_n_oe), .link_busy(link_busy));
`default_nettype wire

// File: dsp_rx_model.sv
// Receiver model: input-only byte port with a set stall
`default_nettype none
module dsp_rx_model (
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Link
  input wire logic [7:0] byte_data,
  input wire logic byte_strobe_n,
  output logic byte_ready_n,
  // Stall before each ready
  input wire logic [3:0] stall_cyc
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] wait_cnt;
  logic [7:0] got[$];
  // Take a byte after the stall, release ready when strobe ends
  always @(posedge core_clk or posedge sys_rst)
    if (sys_rst)
    begin
      byte_ready_n <= 1'b1;
      wait_cnt <= 4'h0;
    end
    else if (byte_strobe_n)
    begin
      byte_ready_n <= 1'b1;
      wait_cnt <= 4'h0;
    end
    else if (byte_ready_n && wait_cnt == stall_cyc)
    begin
      byte_ready_n <= 1'b0;
      got.push_back(byte_data);
    end
    else if (byte_ready_n)
      wait_cnt <= wait_cnt + 4'h1;
endmodule : dsp_rx_model
`default_nettype wire

// File: pin_sync.sv
// Three-stage pin synchroniser with agreement of the last two stages
`default_nettype none

module pin_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Asynchronous pins and their clean levels
  input wire logic [WIDTH-1:0] pin,
  output logic [WIDTH-1:0] level
);

  // ==========================================================
  // Per-bit chain
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1)
    begin : g_bit
      logic meta;
      logic second;
      logic third;
      logic held;
      logic next_held;

      // Accept a change only once stages two and three agree
      always_comb
      begin
        next_held = held;
        if (second == third)
        begin
          next_held = third;
        end
      end

      // Stage registers; the first stage feeds only the second
      always_ff @(posedge core_clk or posedge sys_rst)
      begin
        if (sys_rst)
        begin
          meta <= RESET_VALUE[i];
          second <= RESET_VALUE[i];
          third <= RESET_VALUE[i];
          held <= RESET_VALUE[i];
        end
        else
        begin
          meta <= pin[i];
          second <= meta;
          third <= second;
          held <= next_held;
        end
      end

      assign level[i] = held;
    end
  endgenerate

endmodule : pin_sync

`default_nettype wire
